// file: hw/epwm_bridge.sv
/*
  enhanced pwm bridge output stage with apb register slave, timer base,
  half/full bridge steering, deadband and auto-shutdown.
  assumes pclk is the oscillator clock and shutdown pins are synchronous to it.
*/
`timescale 1ns/1ps
module epwm_bridge
  import epwm_pkg::*;
#(
  parameter int DB_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shutdown_int_pin_n,
  input wire logic shutdown_b4_pin_n,
  output logic bridge_out_a,
  output logic bridge_out_a_oe,
  output logic bridge_out_b,
  output logic bridge_out_b_oe,
  output logic bridge_out_c,
  output logic bridge_out_c_oe,
  output logic bridge_out_d,
  output logic bridge_out_d_oe
);
  logic [7:0] period_value_r;
  logic [7:0] duty_high_byte_r;
  logic [7:0] output_config_r;
  logic [2:0] timer_ctrl_r;
  logic [7:0] restart_deadband_config_r;
  logic [6:0] shutdown_control_r;
  logic shutdown_event_flag_r;
  logic shutdown_event_flag_nxt;
  logic [7:0] period_timer_count_r;
  logic [5:0] presc_r;
  logic [9:0] duty_l_r;
  logic [1:0] mode_l_r;
  logic [1:0] pol_l_r;
  logic [DB_W-1:0] dead_l_r;
  logic pwm_r;
  logic hold_r;
  logic hold_nxt;
  logic [DB_W+1:0] db_cnt_r [2];
  logic [1:0] db_raw;
  logic [1:0] db_act;

  // apb decode
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite & pready;
  wire hit_count = paddr == EPWM_ADDR_COUNT;
  wire hit_timer = paddr == EPWM_ADDR_TIMER;
  wire hit_duty = paddr == EPWM_ADDR_DUTY;
  wire hit_config = paddr == EPWM_ADDR_CONFIG;
  wire hit_dead = paddr == EPWM_ADDR_DEADBAND;
  wire hit_sd = paddr == EPWM_ADDR_SHUTDOWN;
  wire hit_period = paddr == EPWM_ADDR_PERIOD;
  wire mapped = hit_count | hit_timer | hit_duty | hit_config | hit_dead | hit_sd | hit_period;
  wire [7:0] sd_read = {shutdown_event_flag_r, shutdown_control_r[6], 1'b0, shutdown_control_r[4:0]};
  wire [7:0] rd_byte = hit_count ? period_timer_count_r :
                       hit_timer ? {5'h00, timer_ctrl_r} :
                       hit_duty ? duty_high_byte_r :
                       hit_config ? output_config_r :
                       hit_dead ? restart_deadband_config_r :
                       hit_sd ? sd_read :
                       hit_period ? period_value_r : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_value_r <= EPWM_RST_PERIOD;
      duty_high_byte_r <= EPWM_RST_ZERO;
      output_config_r <= EPWM_RST_ZERO;
      timer_ctrl_r <= 3'h0;
      restart_deadband_config_r <= EPWM_RST_ZERO;
      shutdown_control_r <= 7'h00;
    end else if (wr_en) begin
      if (hit_period) period_value_r <= pwdata[7:0];
      if (hit_duty) duty_high_byte_r <= pwdata[7:0];
      if (hit_config) output_config_r <= pwdata[7:0];
      if (hit_timer) timer_ctrl_r <= pwdata[2:0];
      if (hit_dead) restart_deadband_config_r <= pwdata[7:0];
      if (hit_sd) shutdown_control_r <= pwdata[6:0] & EPWM_SD_WMASK[6:0];
    end
  end

  // timer base: prescaled tick and fine bits
  function automatic logic [5:0] presc_limit(input logic [1:0] sel);
    presc_limit = (sel == 2'b00) ? EPWM_LIM_PS1 : (sel == 2'b01) ? EPWM_LIM_PS4 : EPWM_LIM_PS16;
  endfunction

  function automatic logic [1:0] fine_bits(input logic [5:0] p, input logic [1:0] sel);
    fine_bits = (sel == 2'b00) ? p[1:0] : (sel == 2'b01) ? p[3:2] : p[5:4];
  endfunction

  wire timer_on = timer_ctrl_r[EPWM_TMR_ON];
  wire tick = timer_on & (presc_r == presc_limit(timer_ctrl_r[1:0]));
  wire at_period = period_timer_count_r == period_value_r;
  wire pstart = tick & at_period;
  wire [1:0] fine = fine_bits(presc_r, timer_ctrl_r[1:0]);
  wire duty_match = {period_timer_count_r, fine} == duty_l_r;
  // live waveform drops in the match cycle, so active time equals duty
  wire pwm_live = pwm_r & ~duty_match;
  wire [9:0] duty_buf = {duty_high_byte_r, output_config_r[EPWM_CFG_DLSB+1:EPWM_CFG_DLSB]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 6'h00;
      period_timer_count_r <= 8'h00;
    end else if (!timer_on) begin
      presc_r <= 6'h00;
    end else if (tick) begin
      presc_r <= 6'h00;
      period_timer_count_r <= at_period ? 8'h00 : period_timer_count_r + 8'h01;
    end else begin
      presc_r <= presc_r + 6'h01;
    end
  end

  // control latched at the period boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_l_r <= 10'h000;
      mode_l_r <= EPWM_MODE_SINGLE;
      pol_l_r <= 2'h0;
      dead_l_r <= '0;
      pwm_r <= 1'b0;
    end else if (pstart) begin
      duty_l_r <= duty_buf;
      mode_l_r <= output_config_r[EPWM_CFG_DIR:EPWM_CFG_FULL];
      pol_l_r <= output_config_r[EPWM_CFG_POL_AC:EPWM_CFG_POL_BD];
      dead_l_r <= restart_deadband_config_r[DB_W-1:0];
      pwm_r <= duty_buf != 10'h000;
    end else if (pwm_r && duty_match) begin
      pwm_r <= 1'b0;
    end
  end

  // deadband: delay only rising edges of the two half-bridge legs
  wire [DB_W+1:0] db_target = {dead_l_r, 2'b00};
  assign db_raw = {~pwm_live, pwm_live};
  generate
    for (genvar i = 0; i < 2; i++) begin : g_db
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          db_cnt_r[i] <= '0;
        end else if (!db_raw[i]) begin
          db_cnt_r[i] <= '0;
        end else if (db_cnt_r[i] != db_target) begin
          db_cnt_r[i] <= db_cnt_r[i] + 1'b1;
        end
      end
      assign db_act[i] = db_raw[i] & (db_cnt_r[i] == db_target);
    end
  endgenerate

  // shutdown sources and status flag
  wire src_int = shutdown_control_r[EPWM_SD_EN_INT] & ~shutdown_int_pin_n;
  wire src_b4 = shutdown_control_r[EPWM_SD_EN_B4] & ~shutdown_b4_pin_n;
  wire sd_event = src_int | src_b4;
  wire sd_wr = wr_en & hit_sd;
  wire restart_en = restart_deadband_config_r[EPWM_DB_RESTART];

  always_comb begin
    shutdown_event_flag_nxt = shutdown_event_flag_r;
    if (restart_en && !sd_event) shutdown_event_flag_nxt = 1'b0;
    if (sd_wr && !sd_event) shutdown_event_flag_nxt = pwdata[EPWM_SD_FLAG];
    if (sd_event) shutdown_event_flag_nxt = 1'b1;
  end

  assign hold_nxt = shutdown_event_flag_nxt | (hold_r & ~pstart);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_event_flag_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      shutdown_event_flag_r <= shutdown_event_flag_nxt;
      hold_r <= hold_nxt;
    end
  end

  // output steering
  wire pwm_on = output_config_r[EPWM_CFG_EN_HI:EPWM_CFG_EN_HI-1] == 2'b11;
  wire full_l = mode_l_r[0];
  wire dir_change = full_l & output_config_r[EPWM_CFG_FULL] &
                    (output_config_r[EPWM_CFG_DIR] != mode_l_r[1]);
  wire swap = dir_change & at_period & timer_on;
  wire swap_rev = swap ? output_config_r[EPWM_CFG_DIR] : mode_l_r[1];
  wire act_a = pwm_on & ((mode_l_r == EPWM_MODE_SINGLE & pwm_live) | (mode_l_r == EPWM_MODE_HALF & db_act[0]) |
               (full_l & ~swap_rev));
  wire act_b = pwm_on & ((mode_l_r == EPWM_MODE_HALF & db_act[1]) |
               (mode_l_r == EPWM_MODE_REV & ~swap & pwm_live));
  wire act_c = pwm_on & full_l & swap_rev;
  wire act_d = pwm_on & mode_l_r == EPWM_MODE_FWD & ~swap & pwm_live;
  wire [1:0] pss_ac = shutdown_control_r[EPWM_SD_PSS_AC+1:EPWM_SD_PSS_AC];
  wire [1:0] pss_bd = shutdown_control_r[EPWM_SD_PSS_BD+1:EPWM_SD_PSS_BD];
  wire pol_ac = pwm_on ? pol_l_r[1] : 1'b0;
  wire pol_bd = pwm_on ? pol_l_r[0] : 1'b0;
  wire lvl_a = hold_nxt ? pss_ac[0] : act_a ^ pol_ac;
  wire lvl_c = hold_nxt ? pss_ac[0] : act_c ^ pol_ac;
  wire lvl_b = hold_nxt ? pss_bd[0] : act_b ^ pol_bd;
  wire lvl_d = hold_nxt ? pss_bd[0] : act_d ^ pol_bd;
  wire oe_ac = ~(hold_nxt & pss_ac[1]);
  wire oe_bd = ~(hold_nxt & pss_bd[1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_out_a <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_out_c <= 1'b0;
      bridge_out_d <= 1'b0;
      bridge_out_a_oe <= 1'b1;
      bridge_out_b_oe <= 1'b1;
      bridge_out_c_oe <= 1'b1;
      bridge_out_d_oe <= 1'b1;
    end else begin
      bridge_out_a <= lvl_a;
      bridge_out_b <= lvl_b;
      bridge_out_c <= lvl_c;
      bridge_out_d <= lvl_d;
      bridge_out_a_oe <= oe_ac;
      bridge_out_b_oe <= oe_bd;
      bridge_out_c_oe <= oe_ac;
      bridge_out_d_oe <= oe_bd;
    end
  end

  // checks
  a_period_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    pstart |=> period_timer_count_r == 8'h00 && duty_l_r == $past(duty_buf))
    else $error("timer or duty not reloaded at period end");

  a_zero_duty: assert property (@(posedge pclk) disable iff (!presetn)
    pstart && duty_buf == 10'h000 |=> !pwm_r)
    else $error("zero duty set the output");

  a_duty_end: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_r && duty_match && !pstart |=> !pwm_r)
    else $error("active phase not ended at duty match");

  a_dead_rise: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pwm_r) && mode_l_r == EPWM_MODE_HALF && dead_l_r != '0 |-> !db_act[0] ##1 !db_act[0])
    else $error("half-bridge rising edge not delayed");

  a_dead_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(pwm_live) |-> !db_act[0])
    else $error("falling edge delayed");

  a_full_nodead: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_on && mode_l_r == EPWM_MODE_FWD && !swap |-> act_d == pwm_live && act_a && !act_b && !act_c)
    else $error("forward bridge output wrong");

  a_swap_off: assert property (@(posedge pclk) disable iff (!presetn)
    swap |-> !act_b && !act_d && (act_c == output_config_r[EPWM_CFG_DIR]))
    else $error("direction swap outputs wrong");

  a_sd_set: assert property (@(posedge pclk) disable iff (!presetn)
    sd_event |=> shutdown_event_flag_r && hold_r)
    else $error("shutdown event did not set flag");

  a_sd_wr_block: assert property (@(posedge pclk) disable iff (!presetn)
    sd_wr && sd_event && !pwdata[EPWM_SD_FLAG] |=> shutdown_event_flag_r)
    else $error("flag cleared during active shutdown");

  a_no_source: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown_control_r[EPWM_SD_EN_INT] == 1'b0 && shutdown_control_r[EPWM_SD_EN_B4] == 1'b0 &&
    !shutdown_event_flag_r && !sd_wr |=> !shutdown_event_flag_r)
    else $error("shutdown without enabled source");

  a_restart: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown_event_flag_r && restart_en && !sd_event && !sd_wr |=> !shutdown_event_flag_r)
    else $error("auto restart did not clear flag");

  a_hold_period: assert property (@(posedge pclk) disable iff (!presetn)
    hold_r && !pstart |=> hold_r)
    else $error("shutdown released inside a period");

  a_safe_low: assert property (@(posedge pclk) disable iff (!presetn)
    hold_nxt && pss_ac == 2'b00 |=> !bridge_out_a && !bridge_out_c && bridge_out_a_oe)
    else $error("pair a/c not driven low in shutdown");

  a_safe_high: assert property (@(posedge pclk) disable iff (!presetn)
    hold_nxt && pss_ac == 2'b01 |=> bridge_out_a && bridge_out_c && bridge_out_a_oe && bridge_out_c_oe)
    else $error("pair a/c not driven high in shutdown");

  a_safe_tri: assert property (@(posedge pclk) disable iff (!presetn)
    hold_nxt && pss_bd[1] |=> !bridge_out_b_oe && !bridge_out_d_oe)
    else $error("pair b/d not released in shutdown");

  a_pol_single: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_on && !hold_nxt && mode_l_r == EPWM_MODE_SINGLE |-> lvl_a == (pwm_live ^ pol_l_r[1]))
    else $error("output a polarity wrong");

  a_force_flag: assert property (@(posedge pclk) disable iff (!presetn)
    sd_wr && pwdata[EPWM_SD_FLAG] |=> shutdown_event_flag_r && hold_r)
    else $error("software write did not force shutdown");

  a_half_pair: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_on && mode_l_r == EPWM_MODE_HALF |-> !(act_a && act_b) && !act_c && !act_d)
    else $error("half-bridge outputs wrong");

  a_dead_b_rise: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(pwm_live) && mode_l_r == EPWM_MODE_HALF && dead_l_r != '0 |-> !db_act[1])
    else $error("complement rising edge not delayed");

  a_dead_wait: assert property (@(posedge pclk) disable iff (!presetn)
    db_act[1] && dead_l_r != '0 |-> $past(db_raw[1]))
    else $error("complement active before deadband elapsed");

  a_rev_out: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_on && mode_l_r == EPWM_MODE_REV && !swap |-> act_c && act_b == pwm_live && !act_a && !act_d)
    else $error("reverse bridge output wrong");

  a_dir_latched: assert property (@(posedge pclk) disable iff (!presetn)
    !pstart |=> $stable(mode_l_r))
    else $error("mode changed inside a period");

  a_pin_event: assert property (@(posedge pclk) disable iff (!presetn)
    (!shutdown_int_pin_n && shutdown_control_r[EPWM_SD_EN_INT]) ||
    (!shutdown_b4_pin_n && shutdown_control_r[EPWM_SD_EN_B4]) |=> shutdown_event_flag_r)
    else $error("enabled pin low did not set flag");

  a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    shutdown_event_flag_r |-> hold_r)
    else $error("outputs not held while flag set");

  a_single_only: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_on && mode_l_r == EPWM_MODE_SINGLE |-> !act_b && !act_c && !act_d)
    else $error("single mode drove b, c or d");
endmodule // epwm_bridge

// file: hw/epwm_pkg.sv
/*
  constants for the enhanced pwm bridge stage: register indexes, byte addresses,
  field positions, reset values and output configuration codes.
  assumes an apb master with 32-bit data and pclk as the oscillator clock.
*/
// Summary of operation
// - at period match: timer clears, output set unless duty zero, duty latched
// - active phase ends when latched duty equals timer count with two fine bits
// - two polarity bits select active level for pair a/c and pair b/d
// - software writing one to shutdown flag forces the shutdown state
// - half-bridge: waveform on a, complement on b, c and d unused
// - half-bridge: rising edges delayed by deadband count of four-clock cycles
// - deadband delays only inactive-to-active edges, falling edges are immediate
// - deadband longer than active time keeps that output inactive all cycle
// - full-bridge forward: a active, d modulated, b and c inactive
// - full-bridge reverse: c active, b modulated, a and d inactive
// - direction bit written any time, new direction applied from next period
// - on direction change: b,d off and a,c swap one timer tick early
// - full-bridge modes insert no deadband delay
// - low shutdown pin triggers shutdown when its enable bit is set
// - with both enables clear pins never cause shutdown
// - shutdown state per pair: 00 low, 01 high, 1x tri-state
// - hardware sets shutdown flag on event; outputs held while flag set
// - restart enabled: flag clears when cause ends; else software clears it
// - flag set at period start holds shutdown all period; resume next period
// - software writes to shutdown flag ignored while a shutdown cause is active
package epwm_pkg;
  localparam logic [9:0] EPWM_IDX_COUNT = 10'h011;
  localparam logic [9:0] EPWM_IDX_TIMER = 10'h012;
  localparam logic [9:0] EPWM_IDX_DUTY = 10'h015;
  localparam logic [9:0] EPWM_IDX_CONFIG = 10'h017;
  localparam logic [9:0] EPWM_IDX_DEADBAND = 10'h018;
  localparam logic [9:0] EPWM_IDX_SHUTDOWN = 10'h019;
  localparam logic [9:0] EPWM_IDX_PERIOD = 10'h092;
  localparam logic [11:0] EPWM_ADDR_COUNT = {EPWM_IDX_COUNT, 2'h0};
  localparam logic [11:0] EPWM_ADDR_TIMER = {EPWM_IDX_TIMER, 2'h0};
  localparam logic [11:0] EPWM_ADDR_DUTY = {EPWM_IDX_DUTY, 2'h0};
  localparam logic [11:0] EPWM_ADDR_CONFIG = {EPWM_IDX_CONFIG, 2'h0};
  localparam logic [11:0] EPWM_ADDR_DEADBAND = {EPWM_IDX_DEADBAND, 2'h0};
  localparam logic [11:0] EPWM_ADDR_SHUTDOWN = {EPWM_IDX_SHUTDOWN, 2'h0};
  localparam logic [11:0] EPWM_ADDR_PERIOD = {EPWM_IDX_PERIOD, 2'h0};
  localparam logic [7:0] EPWM_RST_PERIOD = 8'hFF;
  localparam logic [7:0] EPWM_RST_ZERO = 8'h00;
  // config register fields
  localparam int EPWM_CFG_DIR = 7;
  localparam int EPWM_CFG_FULL = 6;
  localparam int EPWM_CFG_DLSB = 4;
  localparam int EPWM_CFG_EN_HI = 3;
  localparam int EPWM_CFG_POL_AC = 1;
  localparam int EPWM_CFG_POL_BD = 0;
  // timer control fields
  localparam int EPWM_TMR_ON = 2;
  // deadband register fields
  localparam int EPWM_DB_RESTART = 7;
  // shutdown register fields
  localparam int EPWM_SD_FLAG = 7;
  localparam int EPWM_SD_EN_INT = 6;
  localparam int EPWM_SD_EN_B4 = 4;
  localparam int EPWM_SD_PSS_AC = 2;
  localparam int EPWM_SD_PSS_BD = 0;
  localparam logic [7:0] EPWM_SD_WMASK = 8'h5F;
  // clocks per instruction cycle
  localparam int EPWM_TOSC_PER_TCY = 4;
  localparam logic [5:0] EPWM_LIM_PS1 = 6'h03;
  localparam logic [5:0] EPWM_LIM_PS4 = 6'h0F;
  localparam logic [5:0] EPWM_LIM_PS16 = 6'h3F;
  typedef enum logic [1:0] {
    EPWM_MODE_SINGLE = 2'b00,
    EPWM_MODE_FWD = 2'b01,
    EPWM_MODE_HALF = 2'b10,
    EPWM_MODE_REV = 2'b11
  } epwm_mode_t;
endpackage

// file: verification/epwm_drivers.sv
/*
  bridge driver model: turns each pin's level and enable into the level the
  power switch driver sees.
  assumes pull-downs hold a released pin low so the switch stays off.
*/
`timescale 1ns/1ps
module epwm_drivers (
  input wire logic [3:0] out,
  input wire logic [3:0] oe,
  output logic [3:0] line
);
  // released pin pulled low; drivers switch off at once
  assign line = oe & out;
endmodule // epwm_drivers

// file: verification/tb_epwm_bridge.sv
/*
  self-checking bench for the enhanced pwm bridge stage over apb.
  assumes pclk is the oscillator clock and both shutdown pins idle high.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h got %h", n, e, g); end end
module tb_epwm_bridge;
  import epwm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic sd_int_n = 1'b1;
  logic sd_b4_n = 1'b1;
  logic [3:0] out, oe, line;
  int errors = 0;
  int comparisons = 0;
  int k;
  always #12.5 pclk = ~pclk;
  epwm_bridge u_epwm_bridge (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_int_pin_n(sd_int_n), .shutdown_b4_pin_n(sd_b4_n),
    .bridge_out_a(out[0]), .bridge_out_a_oe(oe[0]), .bridge_out_b(out[1]), .bridge_out_b_oe(oe[1]),
    .bridge_out_c(out[2]), .bridge_out_c_oe(oe[2]), .bridge_out_d(out[3]), .bridge_out_d_oe(oe[3]));
  epwm_drivers u_epwm_drivers (.out(out), .oe(oe), .line(line));
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; data and error taken at the edge that sees pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), {24'h000000, d}, rd)
    `CHK("pslverr", 1'b0, err)
  endtask
  // high cycles of each pin over 64 cycles, four 16-cycle periods at prescale 1
  task automatic counts(input int ea, input int eb, input int ec, input int ed);
    int n[4];
    n = '{0, 0, 0, 0};
    cyc(40);
    repeat (64) begin
      @(posedge pclk);
      for (int i = 0; i < 4; i++) n[i] += (line[i] === 1'b1);
    end
    `CHK("count a", ea, n[0])
    `CHK("count b", eb, n[1])
    `CHK("count c", ec, n[2])
    `CHK("count d", ed, n[3])
  endtask
  initial begin
    cyc(20000);
    errors++;
    results();
  end
  initial begin
    cyc(4);
    presetn <= 1'b1;
    rdchk(EPWM_ADDR_DEADBAND, 8'h00);
    rdchk(EPWM_ADDR_SHUTDOWN, 8'h00);
    rdchk(EPWM_ADDR_PERIOD, 8'hFF);
    rdchk(EPWM_ADDR_CONFIG, 8'h00);
    wr(EPWM_ADDR_DEADBAND, 8'hFF);
    rdchk(EPWM_ADDR_DEADBAND, 8'hFF);
    xfer(1'b0, 12'h100, 8'h00);
    `CHK("unmapped pslverr", 1'b1, err)
    `CHK("unmapped data", 32'h00000000, rd)
    $display("test registers done");
    wr(EPWM_ADDR_PERIOD, 8'h03);
    wr(EPWM_ADDR_DUTY, 8'h01);
    wr(EPWM_ADDR_DEADBAND, 8'h01);
    wr(EPWM_ADDR_CONFIG, 8'h2C);
    wr(EPWM_ADDR_TIMER, 8'h04);
    counts(24, 0, 0, 0);
    wr(EPWM_ADDR_CONFIG, 8'h2E);
    counts(40, 0, 64, 0);
    wr(EPWM_ADDR_CONFIG, 8'hAC);
    counts(8, 24, 0, 0);
    wr(EPWM_ADDR_DEADBAND, 8'h07);
    counts(0, 0, 0, 0);
    wr(EPWM_ADDR_DEADBAND, 8'h01);
    wr(EPWM_ADDR_CONFIG, 8'h6C);
    counts(64, 0, 0, 24);
    $display("test modes done");
    wr(EPWM_ADDR_CONFIG, 8'hEC);
    for (k = 0; k < 40 && line[2] !== 1'b1; k++) @(posedge pclk);
    `CHK("swap a b d", 3'b000, {line[0], line[1], line[3]})
    `CHK("swap c", 1'b1, line[2])
    counts(0, 24, 64, 0);
    wr(EPWM_ADDR_CONFIG, 8'h6C);
    $display("test direction done");
    wr(EPWM_ADDR_SHUTDOWN, 8'h06);
    sd_int_n <= 1'b0;
    sd_b4_n <= 1'b0;
    cyc(6);
    rdchk(EPWM_ADDR_SHUTDOWN, 8'h06);
    `CHK("oe b", 1'b1, oe[1])
    sd_int_n <= 1'b1;
    sd_b4_n <= 1'b1;
    wr(EPWM_ADDR_SHUTDOWN, 8'h86);
    cyc(3);
    `CHK("forced a b_oe", 2'b10, {line[0], oe[1]})
    rdchk(EPWM_ADDR_SHUTDOWN, 8'h86);
    wr(EPWM_ADDR_SHUTDOWN, 8'h46);
    cyc(2);
    sd_int_n <= 1'b0;
    cyc(3);
    `CHK("shutdown a c b d", 4'b1100, {line[0], line[2], line[1], line[3]})
    `CHK("shutdown oe", 4'b0101, oe)
    rdchk(EPWM_ADDR_SHUTDOWN, 8'hC6);
    wr(EPWM_ADDR_SHUTDOWN, 8'h46);
    rdchk(EPWM_ADDR_SHUTDOWN, 8'hC6);
    sd_int_n <= 1'b1;
    cyc(3);
    rdchk(EPWM_ADDR_SHUTDOWN, 8'hC6);
    `CHK("held oe", 4'b0101, oe)
    wr(EPWM_ADDR_SHUTDOWN, 8'h46);
    rdchk(EPWM_ADDR_SHUTDOWN, 8'h46);
    counts(64, 0, 0, 24);
    wr(EPWM_ADDR_SHUTDOWN, 8'h13);
    wr(EPWM_ADDR_DEADBAND, 8'h81);
    sd_b4_n <= 1'b0;
    cyc(3);
    `CHK("b4 a c", 2'b00, {line[0], line[2]})
    `CHK("b4 oe", 4'b0101, oe)
    sd_b4_n <= 1'b1;
    cyc(3);
    rdchk(EPWM_ADDR_SHUTDOWN, 8'h13);
    $display("test shutdown done");
    wr(EPWM_ADDR_TIMER, 8'h05);
    cyc(30);
    counts(64, 0, 0, 24);
    $display("test prescale done");
    results();
  end
endmodule // tb_epwm_bridge
